/* File: common/mcbw_params.svh */
// Constants for the monitor circular buffer writer
`ifndef MCBW_PARAMS_SVH
`define MCBW_PARAMS_SVH
`define MCBW_CFG_OFS 8'h29
`define MCBW_BASE_OFS 8'h2f
`define MCBW_CFG_RST 16'h0000
`define MCBW_BASE_RST 16'h0000
`define MCBW_MODE_16 2'b01
`define MCBW_MODE_48 2'b11
`define MCBW_AL_CSTART 3'h0
`define MCBW_AL_CNEXT 3'h1
`define MCBW_AL_CEND 3'h2
`define MCBW_AL_CMATCH 3'h3
`define MCBW_AL_DSTART 3'h4
`define MCBW_AL_DNEXT 3'h5
`define MCBW_AL_DEND 3'h6
`define MCBW_AL_DMATCH 3'h7
`define MCBW_LEN16 4'h4
`define MCBW_LEN48 4'h8
`define MCBW_MAX_DATA 6'h23
`endif

/* File: common/mcbw_pkg.sv */
// Types for the monitor circular buffer writer
package mcbw_pkg;
   typedef struct packed {
      logic [47:0] ttag;
      logic [15:0] bsw;
      logic [15:0] resp;
      logic [15:0] len_bytes;
      logic [15:0] cmd;
      logic [5:0] data_cnt;
   } mcbw_msg_t;
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mcbw_ram_t;
   typedef enum logic [2:0] {ST_IDLE, ST_LIST, ST_DATA, ST_CMD, ST_WB} mcbw_state_t;
endpackage : mcbw_pkg

/* File: src/mcbw_writer.sv */
// Data FIFO and circular buffer writer for the bus monitor
`timescale 1ns/1ps
`include "mcbw_params.svh"

// ====================================================
// Data word FIFO (depth must be a power of two)
module mcbw_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;

   assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid = (wp_r != rp_r);
   assign out_data = mem[rp_r[AW-1:0]];

   always_ff @(posedge core_clk) begin
      if (in_valid && in_ready) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wp_r <= wp_r + 1'b1;
         end
         if (out_valid && out_ready) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule : mcbw_fifo

// ====================================================
// Writer top
module mcbw_writer #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Interrupt enables
   input wire logic cmd_irq_en,
   input wire logic data_irq_en,
   // Message descriptor
   input wire logic msg_valid,
   output logic msg_ready,
   input wire mcbw_pkg::mcbw_msg_t msg,
   // Data words
   input wire logic dat_valid,
   output logic dat_ready,
   input wire logic [15:0] dat_word,
   // Shared RAM
   output mcbw_pkg::mcbw_ram_t ram,
   input wire logic ram_gnt,
   input wire logic [15:0] ram_rdata,
   // Events
   output logic cmd_addr_irq,
   output logic data_addr_irq,
   output logic busy
);
   import mcbw_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ====================================================
   // Registers and state
   logic [15:0] cfg_r;
   logic [15:0] base_r;
   logic [15:0] al_r [8];
   mcbw_state_t state_r;
   mcbw_ram_t ram_r;
   logic rd_pend_r;
   logic [3:0] idx_r;
   logic [3:0] ent_r;
   logic [5:0] cnt_r;
   logic [15:0] caddr_r;
   logic [15:0] daddr_r;
   logic [15:0] dptr_r;
   logic mode48_r;
   logic f_valid;
   logic f_ready;
   logic [15:0] f_data;
   logic mode_ok;
   logic wr_done;

   assign mode_ok = (cfg_r[1:0] == `MCBW_MODE_16) || (cfg_r[1:0] == `MCBW_MODE_48);
   assign wr_done = ram_r.req && ram_r.we && ram_gnt;
   assign ram = ram_r;
   assign busy = (state_r != ST_IDLE);

   function automatic logic [15:0] wrap_adv(input logic [15:0] a, s, e);
      wrap_adv = (a == e) ? s : a + 16'h0001;
   endfunction : wrap_adv

   function automatic logic [15:0] clamp(input logic [15:0] a, s, e);
      clamp = (a >= s && a <= e) ? a : s;
   endfunction : clamp

   function automatic logic [15:0] ent_word(input logic [3:0] i, input logic m48,
                                            input mcbw_msg_t m, input logic [15:0] p);
      ent_word = m.cmd;
      if (m48) begin
         unique case (i)
            4'h0: ent_word = m.ttag[15:0];
            4'h1: ent_word = m.ttag[31:16];
            4'h2: ent_word = m.ttag[47:32];
            4'h3: ent_word = m.bsw;
            4'h4: ent_word = m.resp;
            4'h5: ent_word = m.len_bytes;
            4'h6: ent_word = p;
            default: ent_word = m.cmd;
         endcase
      end else begin
         unique case (i)
            4'h0: ent_word = m.bsw;
            4'h1: ent_word = m.ttag[15:0];
            4'h2: ent_word = p;
            default: ent_word = m.cmd;
         endcase
      end
   endfunction : ent_word

   // ====================================================
   // Data FIFO: the monitor can run ahead of RAM access by up to its depth
   mcbw_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .in_valid(dat_valid),
      .in_ready(dat_ready),
      .in_data(dat_word),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   assign f_ready = wr_done && (state_r == ST_DATA);

   // ====================================================
   // Register port
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_r <= `MCBW_CFG_RST;
         base_r <= `MCBW_BASE_RST;
      end else if (reg_wr) begin
         if (reg_addr == `MCBW_CFG_OFS) begin
            cfg_r <= reg_wdata;
         end
         if (reg_addr == `MCBW_BASE_OFS) begin
            base_r <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else begin
         unique case (reg_addr)
            `MCBW_CFG_OFS: reg_rdata <= cfg_r;
            `MCBW_BASE_OFS: reg_rdata <= base_r;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ====================================================
   // Address list capture; host must have loaded words 0 to 7
   always_ff @(posedge core_clk) begin
      if (state_r == ST_LIST && rd_pend_r) begin
         al_r[idx_r[2:0]] <= ram_rdata;
      end
   end

   // ====================================================
   // Sequencer
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         ram_r <= '0;
         rd_pend_r <= 1'b0;
         idx_r <= 4'h0;
         ent_r <= 4'h0;
         cnt_r <= 6'h00;
         caddr_r <= 16'h0000;
         daddr_r <= 16'h0000;
         dptr_r <= 16'h0000;
         mode48_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (msg_valid && mode_ok) begin
                  mode48_r <= (cfg_r[1:0] == `MCBW_MODE_48);
                  idx_r <= 4'h0;
                  ram_r <= '{req: 1'b1, we: 1'b0, addr: base_r, wdata: 16'h0000};
                  state_r <= ST_LIST;
               end
            end
            ST_LIST: begin
               if (ram_r.req && ram_gnt) begin
                  ram_r.req <= 1'b0;
                  rd_pend_r <= 1'b1;
               end else if (rd_pend_r) begin
                  rd_pend_r <= 1'b0;
                  if (idx_r == 4'h7) begin
                     daddr_r <= clamp(al_r[`MCBW_AL_DNEXT], al_r[`MCBW_AL_DSTART],
                                      al_r[`MCBW_AL_DEND]);
                     dptr_r <= clamp(al_r[`MCBW_AL_DNEXT], al_r[`MCBW_AL_DSTART],
                                     al_r[`MCBW_AL_DEND]);
                     cnt_r <= 6'h00;
                     state_r <= ST_DATA;
                  end else begin
                     idx_r <= idx_r + 4'h1;
                     ram_r.req <= 1'b1;
                     ram_r.addr <= base_r + {12'h000, idx_r + 4'h1};
                  end
               end
            end
            ST_DATA: begin
               if (ram_r.req) begin
                  if (ram_gnt) begin
                     ram_r.req <= 1'b0;
                     cnt_r <= cnt_r + 6'h01;
                     daddr_r <= wrap_adv(daddr_r, al_r[`MCBW_AL_DSTART],
                                         al_r[`MCBW_AL_DEND]);
                  end
               end else if (cnt_r == msg.data_cnt || cnt_r == `MCBW_MAX_DATA) begin
                  ent_r <= 4'h0;
                  caddr_r <= clamp(al_r[`MCBW_AL_CNEXT], al_r[`MCBW_AL_CSTART],
                                   al_r[`MCBW_AL_CEND]);
                  state_r <= ST_CMD;
               end else if (f_valid) begin
                  ram_r <= '{req: 1'b1, we: 1'b1, addr: daddr_r, wdata: f_data};
               end
            end
            ST_CMD: begin
               if (ram_r.req) begin
                  if (ram_gnt) begin
                     ram_r.req <= 1'b0;
                     ent_r <= ent_r + 4'h1;
                     caddr_r <= wrap_adv(caddr_r, al_r[`MCBW_AL_CSTART],
                                         al_r[`MCBW_AL_CEND]);
                  end
               end else if (ent_r == (mode48_r ? `MCBW_LEN48 : `MCBW_LEN16)) begin
                  idx_r <= 4'h0;
                  state_r <= ST_WB;
               end else begin
                  ram_r <= '{req: 1'b1, we: 1'b1, addr: caddr_r,
                             wdata: ent_word(ent_r, mode48_r, msg, dptr_r)};
               end
            end
            ST_WB: begin
               if (ram_r.req) begin
                  if (ram_gnt) begin
                     ram_r.req <= 1'b0;
                     idx_r <= idx_r + 4'h1;
                  end
               end else if (idx_r == 4'h2) begin
                  state_r <= ST_IDLE;
               end else begin
                  ram_r <= '{req: 1'b1, we: 1'b1,
                             addr: base_r + {13'h0000, idx_r[0] ? `MCBW_AL_DNEXT
                                                                : `MCBW_AL_CNEXT},
                             wdata: idx_r[0] ? daddr_r : caddr_r};
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign msg_ready = (state_r == ST_WB) && !ram_r.req && (idx_r == 4'h2);

   // ====================================================
   // Buffer address match pulses
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_addr_irq <= 1'b0;
         data_addr_irq <= 1'b0;
      end else begin
         cmd_addr_irq <= wr_done && cmd_irq_en && (state_r == ST_CMD) &&
                         (ram_r.addr == al_r[`MCBW_AL_CMATCH]);
         data_addr_irq <= wr_done && data_irq_en && (state_r == ST_DATA) &&
                          (ram_r.addr == al_r[`MCBW_AL_DMATCH]);
      end
   end

   // ====================================================
   // Checks
   a_ts_word_low: assert property (state_r == ST_CMD && ram_r.req && mode48_r
      && ent_r == 4'h0 |-> ram_r.wdata == msg.ttag[15:0]) else $error("ts low");
   a_entry_starts_w0: assert property ($rose(state_r == ST_CMD) |-> ent_r == 4'h0
      ##1 !ram_r.req || ram_r.addr == caddr_r) else $error("entry start");
   a_cmd_bounds: assert property (state_r == ST_CMD && ram_r.req |->
      ram_r.addr >= al_r[0] && ram_r.addr <= al_r[2]) else $error("cmd bounds");
   a_data_bounds: assert property (state_r == ST_DATA && ram_r.req |->
      ram_r.addr >= al_r[4] && ram_r.addr <= al_r[6]) else $error("data bounds");
   a_wb_targets: assert property (state_r == ST_WB && ram_r.req |-> ram_r.we &&
      (ram_r.addr == base_r + 16'h0001 || ram_r.addr == base_r + 16'h0005))
      else $error("writeback target");
   a_data_irq_match: assert property (wr_done && state_r == ST_DATA && data_irq_en
      && ram_r.addr == al_r[7] |=> data_addr_irq) else $error("data irq");
   a_list_base: assert property (state_r == ST_LIST && ram_r.req |->
      !ram_r.we && ram_r.addr == base_r + {12'h000, idx_r}) else $error("list addr");
   a_entry_len: assert property (state_r == ST_WB |->
      ent_r == (mode48_r ? 4'h8 : 4'h4)) else $error("entry length");
   a_data_count: assert property ($rose(state_r == ST_CMD) |->
      $past(cnt_r) <= 6'h23) else $error("data count");
   a_ptr_word: assert property (state_r == ST_CMD && ram_r.req &&
      ent_r == (mode48_r ? 4'h6 : 4'h2) |-> ram_r.wdata == dptr_r)
      else $error("data pointer");
   a_data_wrap: assert property (state_r == ST_DATA && wr_done && ram_r.addr == al_r[6]
      |=> daddr_r == al_r[4]) else $error("data wrap");
endmodule : mcbw_writer

/* File: verif/mcbw_ram_model.sv */
// Shared RAM model with random grant stalls
`timescale 1ns/1ps
module mcbw_ram_model (
   // Clock
   input wire logic core_clk,
   // Access port
   input wire mcbw_pkg::mcbw_ram_t ram,
   output logic ram_gnt,
   output logic [15:0] ram_rdata
);
   import mcbw_pkg::*;
   logic [15:0] mem [0:4095];
   initial begin
      ram_gnt = 1'b0;
      ram_rdata = 16'h0000;
   end
   // Grant changes off the sampling edge and stalls at random
   always @(negedge core_clk) begin
      ram_gnt <= ram.req && ($urandom_range(1) == 0);
   end
   // Read data only valid one cycle; otherwise it toggles so stale use shows
   always @(posedge core_clk) begin
      if (ram.req && ram_gnt && ram.we)
         mem[ram.addr[11:0]] <= ram.wdata;
      if (ram.req && ram_gnt && !ram.we)
         ram_rdata <= mem[ram.addr[11:0]];
      else
         ram_rdata <= ~ram_rdata;
   end
endmodule : mcbw_ram_model

/* File: verif/test_monitor_circular_buffer_writer.sv */
// Self-checking bench for the monitor circular buffer writer
`timescale 1ns/1ps
`include "mcbw_params.svh"
module test_monitor_circular_buffer_writer;
   import mcbw_pkg::*;
   localparam logic [15:0] BASE = 16'h0100;
   localparam logic [15:0] CS = 16'h0200;
   localparam logic [15:0] CE = 16'h0213;
   localparam logic [15:0] DS = 16'h0400;
   localparam logic [15:0] DE = 16'h0428;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic cmd_irq_en = 1'b0;
   logic data_irq_en = 1'b0;
   logic msg_valid = 1'b0;
   logic msg_ready;
   mcbw_msg_t msg = '0;
   logic dat_valid = 1'b0;
   logic dat_ready;
   logic [15:0] dat_word = 16'h0000;
   mcbw_ram_t ram;
   logic ram_gnt;
   logic [15:0] ram_rdata;
   logic cmd_addr_irq;
   logic data_addr_irq;
   logic busy;
   int error_cnt = 0;
   int check_count = 0;
   int ci_n = 0;
   int di_n = 0;
   logic [15:0] cp;
   logic [15:0] dp;
   logic [15:0] cm;
   logic [15:0] dm;
   logic [15:0] q [$];
   always #20 core_clk = ~core_clk;
   mcbw_writer #(.FIFO_DEPTH(16)) uut (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cmd_irq_en(cmd_irq_en), .data_irq_en(data_irq_en), .msg_valid(msg_valid),
      .msg_ready(msg_ready), .msg(msg), .dat_valid(dat_valid), .dat_ready(dat_ready),
      .dat_word(dat_word), .ram(ram), .ram_gnt(ram_gnt), .ram_rdata(ram_rdata),
      .cmd_addr_irq(cmd_addr_irq), .data_addr_irq(data_addr_irq), .busy(busy));
   mcbw_ram_model ram_m (.core_clk(core_clk), .ram(ram), .ram_gnt(ram_gnt),
      .ram_rdata(ram_rdata));
   // ==============================================
   // Helpers
   function automatic logic [15:0] nx(input logic [15:0] p, s, e);
      return (p == e) ? s : p + 16'h0001;
   endfunction : nx
   task automatic test_done;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmpb(input logic got, exp);
      cmp({15'h0000, got}, {15'h0000, exp});
   endtask : cmpb
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
      @(negedge core_clk);
   endtask : wreg
   task automatic rdchk(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      @(negedge core_clk);
      cmp(reg_rdata, d);
   endtask : rdchk
   task automatic push(input logic [15:0] w);
      logic r;
      int t;
      dat_valid = 1'b1;
      dat_word = w;
      t = 0;
      do begin
         r = dat_ready;
         @(negedge core_clk);
         t++;
      end while (r !== 1'b1 && t < 3000);
   endtask : push
   always @(posedge core_clk) begin
      if (cmd_addr_irq === 1'b1)
         ci_n++;
      if (data_addr_irq === 1'b1)
         di_n++;
      if (ram.req && ram_gnt && ram.we && ram.addr != BASE + 1 && ram.addr != BASE + 5)
         cmpb((ram.addr >= CS && ram.addr <= CE) ||
              (ram.addr >= DS && ram.addr <= DE), 1'b1);
   end
   // ==============================================
   // One message: pre fills the FIFO before the descriptor goes up
   task automatic run_msg(input logic [1:0] mode, input int n, input bit pre);
      mcbw_msg_t m;
      logic [15:0] e [8];
      int k;
      int ec;
      int xc;
      int xd;
      int t;
      m = 118'({$urandom, $urandom, $urandom, $urandom});
      m.data_cnt = 6'(n);
      ec = (mode == `MCBW_MODE_48) ? 8 : 4;
      if (ec == 8)
         e = '{m.ttag[15:0], m.ttag[31:16], m.ttag[47:32], m.bsw, m.resp, m.len_bytes, dp, m.cmd};
      else
         e = '{m.bsw, m.ttag[15:0], dp, m.cmd, 16'h0, 16'h0, 16'h0, 16'h0};
      wreg(`MCBW_CFG_OFS, {14'h0000, mode});
      cmd_irq_en = 1'($urandom);
      data_irq_en = 1'($urandom);
      q.delete();
      for (k = 0; k < n; k++)
         q.push_back(16'($urandom));
      ci_n = 0;
      di_n = 0;
      if (pre) begin
         for (k = 0; k < 16; k++)
            push(q[k]);
         dat_valid = 1'b0;
         repeat (3) @(negedge core_clk);
         cmpb(dat_ready, 1'b0);
      end
      fork
         begin
            for (int j = pre ? 16 : 0; j < n; j++)
               push(q[j]);
            dat_valid = 1'b0;
         end
         begin
            msg = m;
            msg_valid = 1'b1;
            @(negedge core_clk);
            cmpb(busy, 1'b1);
            t = 0;
            while (msg_ready !== 1'b1 && t < 3000) begin
               @(negedge core_clk);
               t++;
            end
            cmpb(msg_ready, 1'b1);
            @(negedge core_clk);
            msg_valid = 1'b0;
            cmpb(busy, 1'b0);
         end
      join
      xc = 0;
      xd = 0;
      for (k = 0; k < ec; k++) begin
         cmp(ram_m.mem[cp[11:0]], e[k]);
         xc += (cmd_irq_en && cp == cm);
         cp = nx(cp, CS, CE);
      end
      for (k = 0; k < n; k++) begin
         cmp(ram_m.mem[dp[11:0]], q[k]);
         xd += (data_irq_en && dp == dm);
         dp = nx(dp, DS, DE);
      end
      cmp(ram_m.mem[BASE + 1], cp);
      cmp(ram_m.mem[BASE + 5], dp);
      cmp(16'(ci_n), 16'(xc));
      cmp(16'(di_n), 16'(xd));
   endtask : run_msg
   // ==============================================
   // Main sequence
   initial begin
      void'($urandom(32'h26b35c12));
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      rdchk(`MCBW_CFG_OFS, `MCBW_CFG_RST);
      rdchk(`MCBW_BASE_OFS, `MCBW_BASE_RST);
      wreg(8'h2a, 16'hffff);
      rdchk(8'h2a, 16'h0000);
      wreg(`MCBW_BASE_OFS, BASE);
      rdchk(`MCBW_BASE_OFS, BASE);
      cp = CS + 16'h0011;
      dp = DS;
      cm = CS + 16'($urandom_range(19));
      dm = DS + 16'($urandom_range(40));
      ram_m.mem[BASE[11:0] + 0] = CS;
      ram_m.mem[BASE[11:0] + 1] = cp;
      ram_m.mem[BASE[11:0] + 2] = CE;
      ram_m.mem[BASE[11:0] + 3] = cm;
      ram_m.mem[BASE[11:0] + 4] = DS;
      ram_m.mem[BASE[11:0] + 5] = dp;
      ram_m.mem[BASE[11:0] + 6] = DE;
      ram_m.mem[BASE[11:0] + 7] = dm;
      // Monitor off: descriptor must sit untaken
      for (int md = 0; md < 4; md += 2) begin
         wreg(`MCBW_CFG_OFS, 16'(md));
         msg_valid = 1'b1;
         repeat (40) @(negedge core_clk);
         cmpb(busy, 1'b0);
         msg_valid = 1'b0;
         @(negedge core_clk);
      end
      run_msg(`MCBW_MODE_48, 0, 1'b0);
      run_msg(`MCBW_MODE_16, 35, 1'b1);
      run_msg(`MCBW_MODE_48, 35, 1'b0);
      for (int i = 0; i < 14; i++)
         run_msg($urandom_range(1) ? `MCBW_MODE_48 : `MCBW_MODE_16, $urandom_range(35), 1'b0);
      test_done();
   end
   initial begin
      #2000000;
      error_cnt++;
      test_done();
   end
endmodule : test_monitor_circular_buffer_writer
